// ===== core/pio_alloc_top.sv
// pulse io terminal allocator: input routing, output binding and register slave
// Contract
// - input bits 00 to 09 route to normal, interrupt, quick, counter or origin
// - a claimed terminal is unavailable to all its other functions
// - output terminal function binds only when an instruction executes on it
// - origin mode 1 or 2 refuses pwm on error counter reset terminals
// - instruction operand picks cw/ccw or pulse plus direction signalling
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pio_consts.svh"

module pio_alloc_top (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write channels
  input  wire logic [`PIO_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read channels
  input  wire logic [`PIO_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // field input terminals
  input  wire logic [`PIO_IN_TERMS-1:0]  in_term_m0,
  input  wire logic [`PIO_IN_TERMS-1:0]  in_term_m1,
  // routed input functions, one port per module
  output var pio_pkg::pio_in_route_t     route_m0,
  output var pio_pkg::pio_in_route_t     route_m1,
  // pulse engine sources, one per pulse output or pwm channel
  input  wire logic [3:0]                pulse_src,
  input  wire logic [3:0]                dir_src,
  input  wire logic [3:0]                ecr_src,
  input  wire logic [3:0]                pwm_src,
  // field output terminals, module 1 in bits 11:6
  output logic [2*`PIO_OUT_TERMS-1:0]    out_term
);

  localparam int NOUT = 2 * `PIO_OUT_TERMS;

  // register state
  logic [`PIO_CFG_W-1:0]     cfg_in_q [2];
  logic [`PIO_CFG_W-1:0]     cfg_in_d [2];
  logic [7:0]                org_mode_q, org_mode_d;
  logic [`PIO_OUT_TERMS-1:0] out_img_q [2];
  logic [`PIO_OUT_TERMS-1:0] out_img_d [2];
  logic [`PIO_CMD_W-1:0]     cmd_q, cmd_d;
  logic                      refused_q, refused_d;
  // bus state
  logic                      bvalid_q, bvalid_d;
  logic [1:0]                bresp_q, bresp_d;
  logic                      rvalid_q, rvalid_d;
  logic [1:0]                rresp_q, rresp_d;
  logic [31:0]               rdata_q, rdata_d;
  // output binding state
  pio_pkg::pio_out_fn_t [NOUT-1:0] out_fn_q, out_fn_d;
  logic [NOUT-1:0]           pin_d;
  logic [NOUT-1:0]           pin_q;

  logic                      wr_go, rd_go, cmd_we, st_clr, refuse_set;
  pio_pkg::pio_cmd_t         cmd;
  logic [1:0]                pidx;
  logic [3:0]                base;
  logic [2*`PIO_FN_W*`PIO_OUT_TERMS-1:0] ofn_flat;
  logic [31:0]               cfg_mrg [2];

  // merge a bus write into a register under byte strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = st[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // origin modes 1 and 2 reserve the error counter reset terminal
  function automatic logic ecr_mode(input logic [1:0] m);
    ecr_mode = (m == `PIO_ORG_MODE1) || (m == `PIO_ORG_MODE2);
  endfunction

  // handshakes: one write and one read outstanding, address and data taken together
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rd_go         = s_axi_arvalid & ~rvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign out_term      = pin_q;

  assign cmd_we = wr_go && (s_axi_awaddr == `PIO_ADDR_CMD) && s_axi_wstrb[0];
  assign st_clr = wr_go && (s_axi_awaddr == `PIO_ADDR_STATUS) && s_axi_wstrb[2]
                  && s_axi_wdata[`PIO_ST_REFUSED];
  assign cmd    = pio_pkg::pio_cmd_t'(s_axi_wdata[`PIO_CMD_W-1:0]);
  assign pidx   = cmd.tgt[1:0];
  assign base   = pidx[1] ? 4'h6 : 4'h0;

  // strobe-merged config words; only the low 30 bits are kept
  assign cfg_mrg[0] = wmerge({2'h0, cfg_in_q[0]}, s_axi_wdata, s_axi_wstrb);
  assign cfg_mrg[1] = wmerge({2'h0, cfg_in_q[1]}, s_axi_wdata, s_axi_wstrb);

  pio_in_alloc u_in_m0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (in_term_m0),
    .cfg     (cfg_in_q[0]),
    .route_q (route_m0)
  );

  pio_in_alloc u_in_m1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (in_term_m1),
    .cfg     (cfg_in_q[1]),
    .route_q (route_m1)
  );

  // software registers; a hardware refusal wins over a same-cycle clear
  always_comb begin
    cfg_in_d   = cfg_in_q;
    org_mode_d = org_mode_q;
    out_img_d  = out_img_q;
    cmd_d      = cmd_q;
    if (wr_go) begin
      case (s_axi_awaddr)
        `PIO_ADDR_CFG_IN0: cfg_in_d[0] = cfg_mrg[0][`PIO_CFG_W-1:0];
        `PIO_ADDR_CFG_IN1: cfg_in_d[1] = cfg_mrg[1][`PIO_CFG_W-1:0];
        `PIO_ADDR_ORG_MODE: org_mode_d = s_axi_wstrb[0] ? s_axi_wdata[7:0] : org_mode_q;
        `PIO_ADDR_M0_OUT: out_img_d[0] = s_axi_wstrb[0] ? s_axi_wdata[5:0] : out_img_q[0];
        `PIO_ADDR_M1_OUT: out_img_d[1] = s_axi_wstrb[0] ? s_axi_wdata[5:0] : out_img_q[1];
        `PIO_ADDR_CMD: cmd_d = s_axi_wstrb[0] ? s_axi_wdata[`PIO_CMD_W-1:0] : cmd_q;
        default: cmd_d = cmd_q;
      endcase
    end
    refused_d = refuse_set | (refused_q & ~st_clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_in_q[0]  <= `PIO_RST_CFG;
      cfg_in_q[1]  <= `PIO_RST_CFG;
      org_mode_q   <= `PIO_RST_ORG;
      out_img_q[0] <= `PIO_RST_IMG;
      out_img_q[1] <= `PIO_RST_IMG;
      cmd_q        <= `PIO_RST_CMD;
      refused_q    <= 1'b0;
    end else begin
      cfg_in_q   <= cfg_in_d;
      org_mode_q <= org_mode_d;
      out_img_q  <= out_img_d;
      cmd_q      <= cmd_d;
      refused_q  <= refused_d;
    end
  end

  // output binding changes only on an executed instruction
  always_comb begin
    out_fn_d   = out_fn_q;
    refuse_set = 1'b0;
    if (cmd_we) begin
      case (cmd.kind)
        pio_pkg::CK_OUT: begin
          if (cmd.tgt < 4'hC) begin
            out_fn_d[cmd.tgt] = pio_pkg::OF_NORMAL;
          end
        end
        pio_pkg::CK_PULSE: begin
          if (!cmd.meth) begin
            out_fn_d[base + {2'h0, pidx[0], 1'b0}] = pio_pkg::OF_CW;
            out_fn_d[base + {2'h0, pidx[0], 1'b1}] = pio_pkg::OF_CCW;
          end else begin
            out_fn_d[base + {3'h0, pidx[0]}] = pio_pkg::OF_PULSE;
            out_fn_d[base + {3'h0, pidx[0]} + 4'h2] = pio_pkg::OF_DIR;
          end
          if (ecr_mode(org_mode_q[pidx*2 +: 2])) begin
            out_fn_d[base + {3'h0, pidx[0]} + 4'h4] = pio_pkg::OF_ECR;
          end
        end
        pio_pkg::CK_PWM: begin
          if (ecr_mode(org_mode_q[pidx*2 +: 2])) begin
            refuse_set = 1'b1;
          end else begin
            out_fn_d[base + {3'h0, pidx[0]} + 4'h4] = pio_pkg::OF_PWM;
          end
        end
        default: out_fn_d = out_fn_q;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_fn_q <= '{default: pio_pkg::OF_NORMAL};
    end else begin
      out_fn_q <= out_fn_d;
    end
  end

  // per-terminal output mux; pulse index follows the fixed terminal layout
  genvar i;
  generate
    for (i = 0; i < NOUT; i++) begin : g_out
      localparam int M   = i / `PIO_OUT_TERMS;
      localparam int L   = i % `PIO_OUT_TERMS;
      localparam int PCW = 2 * M + ((L / 2) % 2);
      localparam int PPD = 2 * M + (L % 2);
      // function mux for every terminal of both modules
      always_comb begin
        case (out_fn_q[i])
          pio_pkg::OF_NORMAL: pin_d[i] = out_img_q[M][L];
          pio_pkg::OF_CW:     pin_d[i] = pulse_src[PCW] & ~dir_src[PCW];
          pio_pkg::OF_CCW:    pin_d[i] = pulse_src[PCW] & dir_src[PCW];
          pio_pkg::OF_PULSE:  pin_d[i] = pulse_src[PPD];
          pio_pkg::OF_DIR:    pin_d[i] = dir_src[PPD];
          pio_pkg::OF_ECR:    pin_d[i] = ecr_src[PPD];
          pio_pkg::OF_PWM:    pin_d[i] = pwm_src[PPD];
          default:            pin_d[i] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign ofn_flat = out_fn_q;

  // bus answers: write response and read data one cycle after acceptance
  always_comb begin
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q & ~s_axi_rready;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      case (s_axi_awaddr)
        `PIO_ADDR_CFG_IN0, `PIO_ADDR_CFG_IN1, `PIO_ADDR_ORG_MODE, `PIO_ADDR_CMD,
        `PIO_ADDR_STATUS, `PIO_ADDR_M0_OUT, `PIO_ADDR_M1_OUT: bresp_d = `PIO_RESP_OKAY;
        default: bresp_d = `PIO_RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = `PIO_RESP_OKAY;
      case (s_axi_araddr)
        `PIO_ADDR_M0_IN:    rdata_d = {22'h000000, route_m0.normal};
        `PIO_ADDR_M1_IN:    rdata_d = {22'h000000, route_m1.normal};
        `PIO_ADDR_M0_OUT:   rdata_d = {26'h0000000, out_img_q[0]};
        `PIO_ADDR_M1_OUT:   rdata_d = {26'h0000000, out_img_q[1]};
        `PIO_ADDR_CFG_IN0:  rdata_d = {2'h0, cfg_in_q[0]};
        `PIO_ADDR_CFG_IN1:  rdata_d = {2'h0, cfg_in_q[1]};
        `PIO_ADDR_ORG_MODE: rdata_d = {24'h000000, org_mode_q};
        `PIO_ADDR_CMD:      rdata_d = {25'h0000000, cmd_q};
        `PIO_ADDR_STATUS:   rdata_d = {11'h000, refused_q, route_m1.bad, route_m0.bad};
        `PIO_ADDR_OFN0:     rdata_d = {14'h0000, ofn_flat[17:0]};
        `PIO_ADDR_OFN1:     rdata_d = {14'h0000, ofn_flat[35:18]};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = `PIO_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `PIO_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= `PIO_RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // checks on the bindings and routes
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_PWM_REFUSE: assert property (
    cmd_we && cmd.kind == pio_pkg::CK_PWM && ecr_mode(org_mode_q[pidx*2 +: 2])
    |=> refused_q && $stable(out_fn_q))
    else $error("pwm bound on reserved error counter reset terminal");

  AST_OUT_BIND: assert property (
    cmd_we && cmd.kind == pio_pkg::CK_OUT && cmd.tgt < 4'hC
    |=> out_fn_q[$past(cmd.tgt)] == pio_pkg::OF_NORMAL)
    else $error("plain output did not bind normal function");

  AST_NO_BIND_IDLE: assert property (
    !cmd_we |=> $stable(out_fn_q))
    else $error("output function changed without an instruction");

  AST_CWCCW: assert property (
    cmd_we && cmd.kind == pio_pkg::CK_PULSE && !cmd.meth && cmd.tgt == 4'h0
    |=> out_fn_q[0] == pio_pkg::OF_CW && out_fn_q[1] == pio_pkg::OF_CCW)
    else $error("cw/ccw pair not bound on pulse output 0");

  AST_PLSDIR: assert property (
    cmd_we && cmd.kind == pio_pkg::CK_PULSE && cmd.meth && cmd.tgt == 4'h3
    |=> out_fn_q[7] == pio_pkg::OF_PULSE && out_fn_q[9] == pio_pkg::OF_DIR)
    else $error("pulse plus direction not bound on pulse output 3");

  AST_TERM2_EXCL: assert property (
    $onehot0({route_m1.normal[2], route_m1.intr[2], route_m1.quick[2],
              route_m1.cnt_z[1], route_m1.org[1]}))
    else $error("terminal 2 feeds more than one function");

  AST_M1_INTR: assert property (
    $past(cfg_in_q[1][2:0]) == 3'h1 |-> route_m1.intr[0] == $past(in_term_m1[0])
    && !route_m1.normal[0])
    else $error("module 1 terminal 0 not routed to interrupt input 4");

  AST_M1_PWM_PIN: assert property (
    out_fn_q[10] == pio_pkg::OF_PWM |=> out_term[10] == $past(pwm_src[2]))
    else $error("pwm channel 2 not driven on module 1 terminal 4");

  AST_M0_ORIGIN: assert property (
    $past(cfg_in_q[0][2:0]) == 3'h4 |-> route_m0.org[0] == $past(in_term_m0[0]))
    else $error("module 0 terminal 0 not routed to origin input");

endmodule
`default_nettype wire

// ===== common/pio_consts.svh
// register offsets, field positions and reset values of the pulse io terminal allocator
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// printed word indices of the image registers; byte address is four times the index
`define PIO_IDX_M0_IN       12'hB90
`define PIO_IDX_M0_OUT      12'hB91
`define PIO_IDX_M1_IN       12'hB92
`define PIO_IDX_M1_OUT      12'hB93
`define PIO_ADDR_M0_IN      ({`PIO_IDX_M0_IN, 2'h0})
`define PIO_ADDR_M0_OUT     ({`PIO_IDX_M0_OUT, 2'h0})
`define PIO_ADDR_M1_IN      ({`PIO_IDX_M1_IN, 2'h0})
`define PIO_ADDR_M1_OUT     ({`PIO_IDX_M1_OUT, 2'h0})

// configuration, command and status words
`define PIO_ADDR_CFG_IN0    14'h0000
`define PIO_ADDR_CFG_IN1    14'h0004
`define PIO_ADDR_ORG_MODE   14'h0008
`define PIO_ADDR_CMD        14'h000C
`define PIO_ADDR_STATUS     14'h0010
`define PIO_ADDR_OFN0       14'h0014
`define PIO_ADDR_OFN1       14'h0018

// field layout
`define PIO_ADDR_W          14
`define PIO_IN_TERMS        10
`define PIO_OUT_TERMS       6
`define PIO_FN_W            3
`define PIO_CFG_W           30
`define PIO_CMD_W           7
`define PIO_ST_REFUSED      20
`define PIO_ORG_MODE1       2'h1
`define PIO_ORG_MODE2       2'h2

// reset values
`define PIO_RST_CFG         30'h00000000
`define PIO_RST_ORG         8'h00
`define PIO_RST_IMG         6'h00
`define PIO_RST_CMD         7'h00

// bus answers
`define PIO_RESP_OKAY       2'h0
`define PIO_RESP_SLVERR     2'h2

`endif

// ===== common/pio_pkg.sv
// types shared by the pulse io terminal allocator
`default_nettype none
package pio_pkg;

  // function claimed by one input terminal
  typedef enum logic [2:0] {IN_NORMAL, IN_INTR, IN_QUICK, IN_HSC, IN_ORIGIN} pio_in_fn_t;

  // function bound to one output terminal
  typedef enum logic [2:0] {OF_NORMAL, OF_CW, OF_CCW, OF_PULSE, OF_DIR, OF_ECR, OF_PWM}
    pio_out_fn_t;

  // kind of instruction that binds output terminals
  typedef enum logic [1:0] {CK_OUT, CK_PULSE, CK_PWM} pio_cmd_kind_t;

  // instruction word; tgt is an output bit, a pulse output or a pwm channel
  typedef struct packed {
    logic          meth;
    pio_cmd_kind_t kind;
    logic [3:0]    tgt;
  } pio_cmd_t;

  // routed input functions of one module; index 1 is the odd counter or pulse output
  typedef struct packed {
    logic [9:0] normal;
    logic [3:0] intr;
    logic [3:0] quick;
    logic [1:0] cnt_a;
    logic [1:0] cnt_b;
    logic [1:0] cnt_z;
    logic [1:0] org;
    logic [1:0] prox;
    logic [1:0] done;
    logic [9:0] bad;
  } pio_in_route_t;

endpackage
`default_nettype wire

// ===== core/pio_in_alloc.sv
// input terminal function router for one pulse io module
`timescale 1ns/100ps
`default_nettype none
`include "pio_consts.svh"

module pio_in_alloc (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // terminals and per-terminal function codes
  input  wire logic [`PIO_IN_TERMS-1:0]  pins,
  input  wire logic [`PIO_CFG_W-1:0]     cfg,
  // routed functions
  output var pio_pkg::pio_in_route_t     route_q
);

  pio_pkg::pio_in_route_t route_d;
  logic [4:0]             claim_w [`PIO_IN_TERMS];
  logic [`PIO_IN_TERMS-1:0] normal_w;
  logic [`PIO_IN_TERMS-1:0] bad_w;

  // which functions each terminal can carry at all
  function automatic logic fn_legal(input int t, input pio_pkg::pio_in_fn_t f);
    case (f)
      pio_pkg::IN_NORMAL: fn_legal = 1'b1;
      pio_pkg::IN_INTR,
      pio_pkg::IN_QUICK:  fn_legal = (t < 4);
      pio_pkg::IN_HSC:    fn_legal = (t == 2) || (t == 3) || (t >= 6);
      pio_pkg::IN_ORIGIN: fn_legal = (t < 6);
      default:            fn_legal = 1'b0;
    endcase
  endfunction

  // one code per terminal, so a terminal never feeds two functions at once
  genvar t;
  generate
    for (t = 0; t < `PIO_IN_TERMS; t++) begin : g_term
      pio_pkg::pio_in_fn_t fn;
      logic                ok;
      assign fn = pio_pkg::pio_in_fn_t'(cfg[t*`PIO_FN_W +: `PIO_FN_W]);
      assign ok = fn_legal(t, fn);
      assign normal_w[t]   = pins[t] & (~ok | (fn == pio_pkg::IN_NORMAL));
      assign bad_w[t]      = ~ok;
      assign claim_w[t][0] = normal_w[t];
      assign claim_w[t][1] = pins[t] & ok & (fn == pio_pkg::IN_INTR);
      assign claim_w[t][2] = pins[t] & ok & (fn == pio_pkg::IN_QUICK);
      assign claim_w[t][3] = pins[t] & ok & (fn == pio_pkg::IN_HSC);
      assign claim_w[t][4] = pins[t] & ok & (fn == pio_pkg::IN_ORIGIN);
    end
  endgenerate

  always_comb begin
    route_d        = '0;
    route_d.normal = normal_w;
    route_d.bad    = bad_w;
    for (int i = 0; i < 4; i++) begin
      route_d.intr[i]  = claim_w[i][1];
      route_d.quick[i] = claim_w[i][2];
    end
    route_d.cnt_z = {claim_w[2][3], claim_w[3][3]};
    route_d.cnt_a = {claim_w[6][3], claim_w[8][3]};
    route_d.cnt_b = {claim_w[7][3], claim_w[9][3]};
    route_d.org   = {claim_w[2][4], claim_w[0][4]};
    route_d.prox  = {claim_w[3][4], claim_w[1][4]};
    route_d.done  = {claim_w[5][4], claim_w[4][4]};
  end

  // routed outputs are registered so every consumer sees one scan-aligned copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q <= '0;
    end else begin
      route_q <= route_d;
    end
  end

endmodule
`default_nettype wire

// ===== tb/pio_field_model.sv
// field wiring model: sensors and encoders driving the input terminals
`timescale 1ns/100ps
`default_nettype none

module pio_field_model (
  // clock
  input  wire logic       aclk,
  // levels the bench wants on the terminals
  input  wire logic [9:0] set_m0,
  input  wire logic [9:0] set_m1,
  // terminals seen by the allocator
  output logic [9:0]      in_term_m0,
  output logic [9:0]      in_term_m1
);
  // sensors switch just after an edge, so the allocator never samples a moving level
  always @(posedge aclk) begin
    in_term_m0 <= set_m0;
    in_term_m1 <= set_m1;
  end
  // a wiring model has no reset; start with every sensor off
  initial begin
    in_term_m0 = 10'h000;
    in_term_m1 = 10'h000;
  end
endmodule
`default_nettype wire

// ===== tb/pio_alloc_top_tb.sv
// self-checking bench for the pulse io terminal allocator
`timescale 1ns/100ps
`default_nettype none
`include "pio_consts.svh"

module pio_alloc_top_tb;
  typedef struct {logic m; int t; logic [2:0] c; int f; int b;} pio_row_t;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0, pulse_src = 4'h0, dir_src = 4'h0, ecr_src = 4'h0, pwm_src = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [9:0]  set_m0 = 10'h000, set_m1 = 10'h000, in_m0, in_m1;
  logic [11:0] out_term;
  logic [31:0] d;
  logic [39:0] exp;
  pio_pkg::pio_in_route_t route_m0, route_m1;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // one row per terminal claim: module, terminal, code, route bit, bad bit
  pio_row_t    rows[17] = '{
    '{1,0,1,26,-1}, '{1,3,2,25,-1}, '{1,2,3,17,-1}, '{1,3,3,16,-1},
    '{1,6,3,21,-1}, '{1,7,3,19,-1}, '{1,8,3,20,-1}, '{1,9,3,18,-1},
    '{1,2,4,15,-1}, '{1,1,4,12,-1}, '{1,5,4,11,-1}, '{1,5,0,35,-1},
    '{1,4,1,34,4}, '{0,2,2,24,-1}, '{0,6,3,21,-1}, '{1,0,7,30,0}, '{0,0,4,14,-1}};

  pio_alloc_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_term_m0(in_m0), .in_term_m1(in_m1), .route_m0(route_m0), .route_m1(route_m1),
    .pulse_src(pulse_src), .dir_src(dir_src), .ecr_src(ecr_src), .pwm_src(pwm_src),
    .out_term(out_term));

  pio_field_model field_u (
    .aclk(aclk), .set_m0(set_m0), .set_m1(set_m1),
    .in_term_m0(in_m0), .in_term_m1(in_m1));

  // free-running 100 mhz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // write: address and data offered together, held until taken, then wait for the answer
  task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] rs);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic w(input logic [13:0] a, input logic [31:0] v);
    logic [1:0] rs;
    wr(a, v, 4'hF, rs);
    chk("write response", 40'h0, 40'(rs));
  endtask

  task automatic cmd(input logic m, input pio_pkg::pio_cmd_kind_t k, input logic [3:0] t);
    pio_pkg::pio_cmd_t c;
    c = '{meth: m, kind: k, tgt: t};
    w(`PIO_ADDR_CMD, 32'(c));
  endtask

  // sample only at the falling edge, after registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_sim;
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    chk("out_term", 40'h0, 40'(out_term));
    chk("route_m1", 40'h0, route_m1);
    rd(`PIO_ADDR_M1_OUT, d, r);
    chk("m1 out image", 40'h0, {r, 6'h0, d});
    $display("test reset done");
    // each claim must show only on its own function
    foreach (rows[i]) begin
      w(rows[i].m ? `PIO_ADDR_CFG_IN1 : `PIO_ADDR_CFG_IN0, 32'(rows[i].c) << (3 * rows[i].t));
      w(rows[i].m ? `PIO_ADDR_CFG_IN0 : `PIO_ADDR_CFG_IN1, 32'h0);
      set_m1 <= rows[i].m ? 10'(1 << rows[i].t) : 10'h000;
      set_m0 <= rows[i].m ? 10'h000 : 10'(1 << rows[i].t);
      settle(3);
      exp = 40'h0;
      exp[rows[i].f] = 1'b1;
      if (rows[i].b >= 0)
        exp[rows[i].b] = 1'b1;
      chk("route", exp, rows[i].m ? route_m1 : route_m0);
      chk("idle route", 40'h0, rows[i].m ? route_m0 : route_m1);
      rd(rows[i].m ? `PIO_ADDR_M1_IN : `PIO_ADDR_M0_IN, d, r);
      chk("input image", 40'(exp[39:30]), {r, 6'h0, d});
    end
    set_m0 <= 10'h000;
    w(`PIO_ADDR_CFG_IN0, 32'h0);
    $display("test input claims done");
    w(`PIO_ADDR_M1_OUT, 32'h3F);
    pulse_src <= 4'hF;
    settle(2);
    chk("plain out", 40'hFC0, 40'(out_term));
    w(`PIO_ADDR_M1_OUT, 32'h0);
    cmd(1'b0, pio_pkg::CK_PULSE, 4'h2);
    settle(2);
    chk("cw out", 40'h040, 40'(out_term));
    @(posedge aclk);
    dir_src <= 4'h4;
    settle(1);
    chk("ccw out", 40'h080, 40'(out_term));
    rd(`PIO_ADDR_OFN1, d, r);
    chk("m1 functions", 40'h11, 40'(d));
    cmd(1'b1, pio_pkg::CK_PULSE, 4'h3);
    dir_src <= 4'hC;
    settle(2);
    chk("pulse dir out", 40'h280, 40'(out_term));
    rd(`PIO_ADDR_OFN1, d, r);
    chk("m1 functions", 40'h819, 40'(d));
    pwm_src <= 4'hF;
    $display("test output binding done");
    // mode 1 on pulse output 2, then mode 2 on pulse output 3
    for (int q = 2; q < 4; q++) begin
      w(`PIO_ADDR_ORG_MODE, q == 2 ? 32'h10 : 32'h80);
      cmd(1'b0, pio_pkg::CK_PWM, 4'(q));
      settle(2);
      chk("refused pwm", 40'h280, 40'(out_term));
      rd(`PIO_ADDR_STATUS, d, r);
      chk("refused flag", 40'h100000, 40'(d));
      wr(`PIO_ADDR_STATUS, 32'h100000, 4'h4, r);
      rd(`PIO_ADDR_STATUS, d, r);
      chk("flag cleared", 40'h0, 40'(d));
    end
    w(`PIO_ADDR_ORG_MODE, 32'h10);
    cmd(1'b0, pio_pkg::CK_PWM, 4'h3);
    cmd(1'b0, pio_pkg::CK_PULSE, 4'h2);
    ecr_src <= 4'hF;
    settle(2);
    chk("ecr and pwm", 40'hE80, 40'(out_term));
    // plain output rebinds terminal 7, cw/ccw on pulse output 0
    cmd(1'b0, pio_pkg::CK_OUT, 4'h7);
    cmd(1'b0, pio_pkg::CK_PULSE, 4'h0);
    settle(2);
    chk("rebind out", 40'hE01, 40'(out_term));
    // mode 0 lets pwm 2 take terminal 10; its source is then switched off
    w(`PIO_ADDR_ORG_MODE, 32'h0);
    cmd(1'b0, pio_pkg::CK_PWM, 4'h2);
    pwm_src <= 4'h8;
    settle(2);
    chk("pwm 2 bound", 40'hA01, 40'(out_term));
    $display("test origin modes done");
    wr(14'h0100, 32'h1, 4'hF, r);
    chk("unmapped write", 40'h2, 40'(r));
    rd(14'h0100, d, r);
    chk("unmapped read", 40'h200000000, {6'h0, r, d});
    $display("test unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(0);
    chk("reset out", 40'h0, 40'(out_term));
    rd(`PIO_ADDR_OFN1, d, r);
    chk("reset functions", 40'h0, 40'(d));
    $display("test second reset done");
    end_sim;
  end
endmodule
`default_nettype wire
